// ===== mac_txfc_defs.svh
/*
 * Constants for the transmit start/stop and receive flow-control block:
 * register offsets, field positions, reset value, write mask and size constants.
 * Assumes inclusion by bare name from the design module and the test bench.
 */
// Function
// RULE1: writing the run command one starts transmission and checks current descriptor
// RULE2: fetch starts from list base, or from position saved at previous stop
// RULE3: descriptor not owned by DMA suspends and sets buffer-unavailable status bit 2
// RULE4: start command acts only while transmission is stopped
// RULE5: software must program list base before the first start command
// RULE6: clearing run command finishes the frame in flight, then stops
// RULE7: on stop, next descriptor position is saved and reused at restart
// RULE8: stop command acts only while running or suspended
// RULE9: release level field bits 12:11 selects full minus 1 to 4 KB
// RULE10: release acts only when flow control is already asserted
// RULE11: trigger level field bits 10:9 selects full minus 1 to 4 KB
// RULE12: thresholds apply only with FIFO of 4 KB or more and enable set
// RULE13: enable bit 8 turns fill-level flow control on; clear means none
// RULE14: assert above trigger level, hold until below release level; the code asserts at or above the trigger level
`ifndef MAC_TXFC_DEFS_SVH
`define MAC_TXFC_DEFS_SVH

`define OFF_OP_MODE      8'h18
`define OFF_STATUS       8'h14
`define OFF_TX_BASE      8'h10
`define OFF_IRQ_MASK     8'h1c
`define OFF_TX_CURR      8'h20

`define BIT_RUN_CMD      13
`define BIT_REL_HI       12
`define BIT_REL_LO       11
`define BIT_TRIG_HI      10
`define BIT_TRIG_LO      9
`define BIT_FC_EN        8
`define BIT_TBU          2
`define BIT_TX_STOPPED   1
`define BIT_FC_ON        0

`define OP_MODE_RST      32'h0000_0000
`define OP_MODE_MASK     32'h0000_3f00
`define KB_BYTES         16'h0400
`define MIN_FC_FIFO      16'h1000

`endif

// ===== mac_txfc_pkg.sv
/*
 * Types for the transmit start/stop and flow-control block.
 * Assumes nothing beyond the defs header.
 */
package mac_txfc_pkg;
    typedef enum logic [1:0] {
        TX_STOPPED,
        TX_RUNNING,
        TX_SUSPENDED
    } tx_state_t;

    typedef struct packed {
        logic [31:0] addr;
        logic        owned;
        logic        valid;
    } desc_in_t;

    typedef struct packed {
        logic [31:0] addr;
        logic        fetch;
    } desc_req_t;
endpackage

// ===== mac_txfc.sv
/*
 * Transmit start/stop command and fill-level receive flow control,
 * with an AHB-Lite register slave and a level interrupt.
 * Assumes single 32-bit word transfers, a descriptor fetcher that answers
 * one request with one valid pulse, and a frame engine reporting frame end.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mac_txfc_defs.svh"

module mac_txfc #(
    parameter int         FIFO_BYTES = 4096,
    parameter logic [31:0] DESC_STEP = 32'h0000_0010
) (
    // clock and reset
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    // ahb-lite slave
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output logic      [31:0]               hrdata,
    output logic                           hreadyout,
    output logic                           hresp,
    // descriptor fetch
    output mac_txfc_pkg::desc_req_t        desc_req,
    input  wire mac_txfc_pkg::desc_in_t    desc_in,
    // frame engine
    output logic                           tx_frame_go,
    input  wire logic                      tx_frame_done,
    // receive fifo and flow control
    input  wire logic [15:0]               rx_fill,
    output logic                           flow_ctl_on,
    // interrupt
    output logic                           irq
);
    localparam logic [15:0] FIFO_SIZE = 16'(FIFO_BYTES);

    mac_txfc_pkg::tx_state_t state_reg;
    logic [31:0] op_mode_reg;
    logic [31:0] tx_base_reg;
    logic [31:0] tx_curr_reg;
    logic [2:0]  status_reg;
    logic [2:0]  mask_reg;
    logic        in_frame_reg;
    logic        fetch_pend_reg;
    logic        base_loaded_reg;
    logic        wr_pend_reg;
    logic        rd_pend_reg;
    logic [7:0]  addr_reg;

    // full minus (code+1) KB, shared by both thresholds
    function automatic logic [15:0] level_of(input logic [1:0] code);
        level_of = FIFO_SIZE - `KB_BYTES * {14'h0000, code} - `KB_BYTES;
    endfunction

    wire logic        addr_ok  = hsel && hready && htrans[1];
    wire logic        wr_op    = wr_pend_reg && addr_reg == `OFF_OP_MODE;
    wire logic        run_new  = hwdata[`BIT_RUN_CMD];
    wire logic        run_old  = op_mode_reg[`BIT_RUN_CMD];
    wire logic        start_ev = wr_op && run_new && !run_old;
    wire logic        stop_ev  = wr_op && !run_new && run_old;
    wire logic        tbu_ev   = desc_in.valid && !desc_in.owned;
    wire logic        rd_stat  = rd_pend_reg && addr_reg == `OFF_STATUS;
    wire logic [15:0] trig_lvl = level_of(op_mode_reg[`BIT_TRIG_HI:`BIT_TRIG_LO]);
    wire logic [15:0] rel_lvl  = level_of(op_mode_reg[`BIT_REL_HI:`BIT_REL_LO]);
    wire logic        fc_allow = op_mode_reg[`BIT_FC_EN] && FIFO_SIZE >= `MIN_FC_FIFO;
    // running stops once idle; suspended stops at once, also when run was
    // cleared while the failing fetch was still outstanding
    wire logic        run_idle  = !run_old && !in_frame_reg && !fetch_pend_reg;
    wire logic        stop_done = (state_reg == mac_txfc_pkg::TX_RUNNING && run_idle)
        || (state_reg == mac_txfc_pkg::TX_SUSPENDED && (stop_ev || !run_old));
    // a read clears only what it returned, so later events survive
    wire logic [2:0]  clr_mask  = rd_stat ? hrdata[2:0] : 3'h0;

    // bus address phase capture; zero wait states
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg    <= 8'h00;
        end else begin
            wr_pend_reg <= addr_ok && hwrite;
            rd_pend_reg <= addr_ok && !hwrite;
            if (addr_ok) begin
                addr_reg <= haddr[7:0];
            end
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // read data registered at address phase so hrdata is a flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            unique case (haddr[7:0])
                `OFF_OP_MODE:  hrdata <= op_mode_reg;
                `OFF_TX_BASE:  hrdata <= tx_base_reg;
                `OFF_STATUS:   hrdata <= {29'h0000_0000, status_reg};
                `OFF_IRQ_MASK: hrdata <= {29'h0000_0000, mask_reg};
                `OFF_TX_CURR:  hrdata <= tx_curr_reg;
                default:       hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // software registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            op_mode_reg <= `OP_MODE_RST;
            tx_base_reg <= 32'h0000_0000;
            mask_reg    <= 3'h0;
        end else if (wr_pend_reg) begin
            unique case (addr_reg)
                `OFF_OP_MODE:  op_mode_reg <= hwdata & `OP_MODE_MASK;
                `OFF_TX_BASE:  tx_base_reg <= hwdata;
                `OFF_IRQ_MASK: mask_reg    <= hwdata[2:0];
                default:       op_mode_reg <= op_mode_reg;
            endcase
        end
    end

    // transmit state machine
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= mac_txfc_pkg::TX_STOPPED;
        end else begin
            unique case (state_reg)
                mac_txfc_pkg::TX_STOPPED: begin
                    // RULE1: start enters running
                    // RULE4: start only from stopped
                    if (start_ev) begin
                        state_reg <= mac_txfc_pkg::TX_RUNNING;
                    end
                end
                mac_txfc_pkg::TX_RUNNING: begin
                    // RULE6: stop waits for frame end
                    if (run_idle) begin
                        state_reg <= mac_txfc_pkg::TX_STOPPED;
                    // RULE3: unowned descriptor suspends
                    end else if (tbu_ev) begin
                        state_reg <= mac_txfc_pkg::TX_SUSPENDED;
                    end
                end
                mac_txfc_pkg::TX_SUSPENDED: begin
                    // RULE8: stop honoured when suspended
                    if (stop_done) begin
                        state_reg <= mac_txfc_pkg::TX_STOPPED;
                    end
                end
            endcase
        end
    end

    // descriptor position and fetch requests
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_curr_reg     <= 32'h0000_0000;
            base_loaded_reg <= 1'b0;
            fetch_pend_reg  <= 1'b0;
            in_frame_reg    <= 1'b0;
            desc_req        <= '0;
            tx_frame_go     <= 1'b0;
        end else begin
            desc_req.fetch <= 1'b0;
            tx_frame_go    <= 1'b0;
            // RULE2: first start uses base, later the saved position
            // RULE5: base must already be programmed
            if (start_ev && state_reg == mac_txfc_pkg::TX_STOPPED && !base_loaded_reg) begin
                tx_curr_reg     <= tx_base_reg;
                base_loaded_reg <= 1'b1;
            end
            if (wr_pend_reg && addr_reg == `OFF_TX_BASE) begin
                base_loaded_reg <= 1'b0;
            end
            if (state_reg == mac_txfc_pkg::TX_RUNNING && run_old
                    && !fetch_pend_reg && !in_frame_reg && !tbu_ev) begin
                desc_req.fetch <= 1'b1;
                desc_req.addr  <= tx_curr_reg;
                fetch_pend_reg <= 1'b1;
            end
            if (desc_in.valid) begin
                fetch_pend_reg <= 1'b0;
                if (desc_in.owned) begin
                    in_frame_reg <= 1'b1;
                    tx_frame_go  <= 1'b1;
                end
            end
            // RULE7: next position kept for restart
            if (tx_frame_done && in_frame_reg) begin
                in_frame_reg <= 1'b0;
                tx_curr_reg  <= tx_curr_reg + DESC_STEP;
            end
        end
    end

    // flow control with hysteresis
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flow_ctl_on <= 1'b0;
        end else if (!fc_allow) begin
            // RULE13: disabled means no flow control
            // RULE12: needs enable and a large fifo
            flow_ctl_on <= 1'b0;
        end else if (!flow_ctl_on) begin
            // RULE11: trigger level
            // RULE14: assert at or above trigger
            flow_ctl_on <= rx_fill >= trig_lvl;
        end else begin
            // RULE9: release level
            // RULE10: release only once asserted
            flow_ctl_on <= !(rx_fill < rel_lvl);
        end
    end

    // sticky status; set wins over read-clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_reg <= 3'h0;
            irq        <= 1'b0;
        end else begin
            // RULE3: buffer unavailable flag
            status_reg[`BIT_TBU] <= tbu_ev
                || (status_reg[`BIT_TBU] && !clr_mask[`BIT_TBU]);
            // RULE6: stopped event
            status_reg[`BIT_TX_STOPPED] <= stop_done
                || (status_reg[`BIT_TX_STOPPED] && !clr_mask[`BIT_TX_STOPPED]);
            status_reg[`BIT_FC_ON] <= (fc_allow && !flow_ctl_on && rx_fill >= trig_lvl)
                || (status_reg[`BIT_FC_ON] && !clr_mask[`BIT_FC_ON]);
            irq <= |(status_reg & mask_reg);
        end
    end

    // RULE4: suspended does not go back to running
    a_start_only_stopped: assert property (@(posedge hclk) disable iff (!hresetn) // RULE4
        state_reg == mac_txfc_pkg::TX_SUSPENDED && !stop_ev |=> state_reg != mac_txfc_pkg::TX_RUNNING)
        else $error("suspended left without stop");
    // RULE1: running after start
    a_start_runs: assert property (@(posedge hclk) disable iff (!hresetn) // RULE1
        state_reg == mac_txfc_pkg::TX_STOPPED && start_ev |=> state_reg == mac_txfc_pkg::TX_RUNNING)
        else $error("start did not run");
    // RULE3: suspend sets flag
    a_tbu_flag: assert property (@(posedge hclk) disable iff (!hresetn) // RULE3
        tbu_ev |=> status_reg[`BIT_TBU])
        else $error("buffer unavailable not flagged");
    // RULE6: no stop mid-frame
    a_frame_finishes: assert property (@(posedge hclk) disable iff (!hresetn) // RULE6
        in_frame_reg && !tx_frame_done |=> state_reg != mac_txfc_pkg::TX_STOPPED)
        else $error("stopped mid-frame");
    // RULE7: position advances per frame
    a_pos_advance: assert property (@(posedge hclk) disable iff (!hresetn) // RULE7
        tx_frame_done && in_frame_reg |=> tx_curr_reg == $past(tx_curr_reg) + DESC_STEP)
        else $error("position not advanced");
    // RULE13: off when disabled
    a_fc_disabled: assert property (@(posedge hclk) disable iff (!hresetn) // RULE13
        !op_mode_reg[`BIT_FC_EN] |=> !flow_ctl_on)
        else $error("flow control while disabled");
    // RULE14: turn-on at trigger level
    a_fc_trigger: assert property (@(posedge hclk) disable iff (!hresetn) // RULE14
        !flow_ctl_on && fc_allow && rx_fill >= trig_lvl |=> flow_ctl_on)
        else $error("flow control not asserted");
    // RULE10: release never sets
    a_fc_hold: assert property (@(posedge hclk) disable iff (!hresetn) // RULE10
        !flow_ctl_on && rx_fill < trig_lvl |=> !flow_ctl_on)
        else $error("flow control rose below trigger");
    // RULE9: release below release level
    a_fc_release: assert property (@(posedge hclk) disable iff (!hresetn) // RULE9
        flow_ctl_on && fc_allow && rx_fill < rel_lvl |=> !flow_ctl_on)
        else $error("flow control not released");
    // RULE6: stop lands in stopped
    a_stop_state: assert property (@(posedge hclk) disable iff (!hresetn) // RULE6
        stop_done |=> state_reg == mac_txfc_pkg::TX_STOPPED)
        else $error("stop did not complete");
    // RULE8: honoured stop is reported
    a_stop_flag: assert property (@(posedge hclk) disable iff (!hresetn) // RULE8
        stop_done |=> status_reg[`BIT_TX_STOPPED])
        else $error("stopped event not flagged");
    // RULE8: stop while stopped ignored
    a_stopped_holds: assert property (@(posedge hclk) disable iff (!hresetn) // RULE8
        state_reg == mac_txfc_pkg::TX_STOPPED && !start_ev
        |=> state_reg == mac_txfc_pkg::TX_STOPPED)
        else $error("left stopped without start");
    // RULE6: running until frame ends
    a_run_until_idle: assert property (@(posedge hclk) disable iff (!hresetn) // RULE6
        state_reg == mac_txfc_pkg::TX_RUNNING && !run_idle && !tbu_ev
        |=> state_reg == mac_txfc_pkg::TX_RUNNING)
        else $error("running left while busy");
    // RULE3: suspended until stopped
    a_susp_holds: assert property (@(posedge hclk) disable iff (!hresetn) // RULE3
        state_reg == mac_txfc_pkg::TX_SUSPENDED && run_old && !stop_ev
        |=> state_reg == mac_txfc_pkg::TX_SUSPENDED)
        else $error("suspended state left early");
    // RULE3: unowned descriptor suspends
    a_tbu_suspend: assert property (@(posedge hclk) disable iff (!hresetn) // RULE3
        state_reg == mac_txfc_pkg::TX_RUNNING && tbu_ev
        |=> state_reg == mac_txfc_pkg::TX_SUSPENDED)
        else $error("unowned descriptor did not suspend");
    // RULE2: first start loads list base
    a_base_load: assert property (@(posedge hclk) disable iff (!hresetn) // RULE2
        state_reg == mac_txfc_pkg::TX_STOPPED && start_ev && !base_loaded_reg
        |=> tx_curr_reg == $past(tx_base_reg))
        else $error("list base not loaded");
    // RULE7: restart keeps saved position
    a_saved_pos: assert property (@(posedge hclk) disable iff (!hresetn) // RULE7
        state_reg == mac_txfc_pkg::TX_STOPPED && start_ev && base_loaded_reg
        |=> $stable(tx_curr_reg))
        else $error("saved position lost");
    // RULE7: position moves only on start or frame end
    a_pos_hold: assert property (@(posedge hclk) disable iff (!hresetn) // RULE7
        !start_ev && !(tx_frame_done && in_frame_reg) |=> $stable(tx_curr_reg))
        else $error("position moved unexpectedly");
    // RULE1: fetch at current position
    a_fetch_addr: assert property (@(posedge hclk) disable iff (!hresetn) // RULE1
        desc_req.fetch |-> desc_req.addr == tx_curr_reg)
        else $error("fetch not at current position");
    // RULE1: fetches only while running
    a_fetch_running: assert property (@(posedge hclk) disable iff (!hresetn) // RULE1
        state_reg != mac_txfc_pkg::TX_RUNNING |=> !desc_req.fetch)
        else $error("fetch outside running");
    // RULE1: owned descriptor starts a frame
    a_go_owned: assert property (@(posedge hclk) disable iff (!hresetn) // RULE1
        desc_in.valid && desc_in.owned |=> tx_frame_go)
        else $error("owned frame not started");
    // RULE12: none unless enabled and deep enough
    a_fc_allow: assert property (@(posedge hclk) disable iff (!hresetn) // RULE12
        !fc_allow |=> !flow_ctl_on)
        else $error("flow control while not allowed");
    // RULE11: rises only at trigger level
    a_fc_rise_cause: assert property (@(posedge hclk) disable iff (!hresetn) // RULE11
        $rose(flow_ctl_on) |-> $past(fc_allow && rx_fill >= trig_lvl))
        else $error("flow control rose without cause");
    // RULE14: falls only below release level or when not allowed
    a_fc_fall_cause: assert property (@(posedge hclk) disable iff (!hresetn) // RULE14
        $fell(flow_ctl_on) |-> $past(!fc_allow || rx_fill < rel_lvl))
        else $error("flow control fell without cause");
    // RULE11: activation is reported
    a_fc_event: assert property (@(posedge hclk) disable iff (!hresetn) // RULE11
        !flow_ctl_on && fc_allow && rx_fill >= trig_lvl |=> status_reg[`BIT_FC_ON])
        else $error("flow activation not flagged");
endmodule
`default_nettype wire

// ===== mac_far_model.sv
/*
 * Far-side model: descriptor memory that answers fetches, and a frame engine.
 * Assumes one fetch pulse for each request and one go pulse for each frame.
 */
`timescale 1ns/1ps
`default_nettype none

module mac_far_model #(
    parameter int FRAME_CYC = 6
) (
    // clock and reset
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    // descriptor side
    input  wire mac_txfc_pkg::desc_req_t desc_req,
    output mac_txfc_pkg::desc_in_t       desc_in,
    input  wire logic [31:0]             own_limit,
    // frame engine side
    input  wire logic                    tx_frame_go,
    output logic                         tx_frame_done
);
    logic [1:0]  f_reg;
    logic [31:0] a1_reg;
    logic [31:0] a2_reg;
    int          fc_reg;
    logic        own;

    // below own_limit the dma owns; between answers the lines show inverted data
    assign own = (a2_reg < own_limit);
    assign desc_in = '{addr: f_reg[1] ? a2_reg : ~a2_reg,
                       owned: f_reg[1] ? own : ~own,
                       valid: f_reg[1]};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            f_reg  <= '0;
            a1_reg <= '0;
            a2_reg <= '0;
        end else begin
            f_reg  <= {f_reg[0], desc_req.fetch};
            a1_reg <= desc_req.addr;
            a2_reg <= a1_reg;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fc_reg        <= 0;
            tx_frame_done <= 1'b0;
        end else begin
            tx_frame_done <= (fc_reg == 1);
            if (tx_frame_go)
                fc_reg <= FRAME_CYC;
            else if (fc_reg != 0)
                fc_reg <= fc_reg - 1;
        end
    end
endmodule

`default_nettype wire

// ===== mac_txfc_test.sv
/*
 * Self-checking bench: AHB-Lite register tasks, transmit start/stop and flow control.
 * Assumes the far-side model answers descriptor fetches and frames.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mac_txfc_defs.svh"

module mac_txfc_test;
    logic                      hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0]               haddr, hwdata, hrdata, own_limit, q;
    logic [1:0]                htrans;
    logic [2:0]                hsize;
    logic [15:0]               rx_fill;
    logic                      tx_frame_go, tx_frame_done, flow_ctl_on, irq;
    mac_txfc_pkg::desc_req_t   desc_req;
    mac_txfc_pkg::desc_in_t    desc_in;
    logic [31:0]               fa [16];
    int                        fetch_cnt, go_cnt, fail_count, cmp_count, lvl;

    assign hready = hreadyout;
    mac_txfc #(.FIFO_BYTES(4096)) mac_txfc_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .desc_req(desc_req), .desc_in(desc_in), .tx_frame_go(tx_frame_go),
        .tx_frame_done(tx_frame_done), .rx_fill(rx_fill), .flow_ctl_on(flow_ctl_on), .irq(irq));
    mac_far_model mac_far_model_i (.hclk(hclk), .hresetn(hresetn), .desc_req(desc_req),
        .desc_in(desc_in), .own_limit(own_limit), .tx_frame_go(tx_frame_go),
        .tx_frame_done(tx_frame_done));

    initial begin
        hclk = 0;
        forever #20 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        if (desc_req.fetch === 1'b1 && fetch_cnt < 16) begin
            fa[fetch_cnt] = desc_req.addr;
            fetch_cnt++;
        end
        if (tx_frame_go === 1'b1)
            go_cnt++;
    end

    task automatic end_sim;
        $display("mismatches %0d comparisons %0d", fail_count, cmp_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic timeout(input string n);
        fail_count++;
        $display("[FAIL] %s expected done seen timeout", n);
        end_sim;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic edge_rdy;
        int i;
        i = 0;
        do begin
            @(posedge hclk);
            i++;
        end while (hreadyout !== 1'b1 && i < 20);
        if (hreadyout !== 1'b1)
            timeout("hready");
    endtask
    // address phase held until hready, then data phase held until hready
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h00_0000, a};
        hwrite <= w;
        hsize  <= 3'b010;
        edge_rdy;
        htrans <= 2'b00;
        hwdata <= d;
        edge_rdy;
        q = hrdata;
        chk("hresp", 32'h0000_0000, {31'h0, hresp});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk(n, e, q);
    endtask
    task automatic wait_irq;
        int i;
        for (i = 0; i < 80 && irq !== 1'b1; i++)
            @(posedge hclk);
        if (irq !== 1'b1)
            timeout("irq");
    endtask
    task automatic fill(input int f, input logic e);
        rx_fill <= f[15:0];
        repeat (3) @(posedge hclk);
        chk("flow_ctl_on", {31'h0, e}, {31'h0, flow_ctl_on});
    endtask

    initial begin
        {hsel, hwrite, htrans, hsize, haddr, hwdata, rx_fill, own_limit} = '0;
        {fetch_cnt, go_cnt, fail_count, cmp_count} = '0;
        hresetn = 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rd("op reset", `OFF_OP_MODE, 32'h0000_0000);
        rd("status reset", `OFF_STATUS, 32'h0000_0000);
        rd("unmapped", 8'h30, 32'h0000_0000);
        wr(`OFF_OP_MODE, 32'hffff_dfff);
        rd("op fields", `OFF_OP_MODE, 32'h0000_1f00);
        wr(`OFF_OP_MODE, 32'h0000_0000);
        rd("fc event", `OFF_STATUS, 32'h0000_0001);
        wr(`OFF_TX_BASE, 32'h0000_1000);
        wr(`OFF_IRQ_MASK, 32'h0000_0007);
        own_limit <= 32'h0000_1020;
        wr(`OFF_OP_MODE, 32'h0000_2000);
        wait_irq;
        chk("first fetch", 32'h0000_1000, fa[0]);
        chk("frames", 32'd2, go_cnt);
        rd("suspend status", `OFF_STATUS, 32'h0000_0004);
        rd("curr", `OFF_TX_CURR, 32'h0000_1020);
        rd("status cleared", `OFF_STATUS, 32'h0000_0000);
        chk("irq cleared", 32'h0, {31'h0, irq});
        own_limit <= 32'h0000_1040;
        wr(`OFF_OP_MODE, 32'h0000_2000);
        repeat (10) @(posedge hclk);
        chk("start ignored", 32'd3, fetch_cnt);
        wr(`OFF_OP_MODE, 32'h0000_0000);
        wait_irq;
        rd("stop status", `OFF_STATUS, 32'h0000_0002);
        wr(`OFF_OP_MODE, 32'h0000_0000);
        repeat (5) @(posedge hclk);
        rd("stop ignored", `OFF_STATUS, 32'h0000_0000);
        wr(`OFF_OP_MODE, 32'h0000_2000);
        wait_irq;
        rd("resuspend", `OFF_STATUS, 32'h0000_0004);
        chk("restart fetch", 32'h0000_1020, fa[3]);
        chk("frames", 32'd4, go_cnt);
        own_limit <= 32'h0000_1100;
        wr(`OFF_OP_MODE, 32'h0000_0000);
        wait_irq;
        rd("stop status", `OFF_STATUS, 32'h0000_0002);
        wr(`OFF_OP_MODE, 32'h0000_2000);
        for (int i = 0; i < 40 && go_cnt < 5; i++)
            @(posedge hclk);
        wr(`OFF_OP_MODE, 32'h0000_0000);
        wait_irq;
        rd("mid-frame stop", `OFF_STATUS, 32'h0000_0002);
        chk("frame finished", 32'd5, go_cnt);
        rd("saved curr", `OFF_TX_CURR, 32'h0000_1050);
        wr(`OFF_IRQ_MASK, 32'h0000_0000);
        for (int c = 0; c < 4; c++) begin
            wr(`OFF_OP_MODE, 32'h0000_0100 | (c << 9) | (c << 11));
            lvl = 4096 - (c + 1) * 1024;
            // full minus 4 KB is level zero: nothing lies below it
            if (c < 3)
                fill(lvl - 1, 1'b0);
            fill(lvl, 1'b1);
            if (c < 3)
                fill(lvl - 1, 1'b0);
        end
        wr(`OFF_OP_MODE, 32'h0000_1100);
        fill(3072, 1'b1);
        fill(2000, 1'b1);
        fill(1023, 1'b0);
        fill(500, 1'b0);
        wr(`OFF_OP_MODE, 32'h0000_0000);
        fill(4000, 1'b0);
        chk("irq masked", 32'h0, {31'h0, irq});
        rd("flow event", `OFF_STATUS, 32'h0000_0001);
        end_sim;
    end
endmodule

`default_nettype wire
